// *** src/ftaa_fifo_if.sv ***
// Interface carrying one lane FIFO's push, pop and state.
// Assumes a single clock shared by both ends.
interface ftaa_fifo_if #(parameter int W = 9, parameter int DEPTH = 8);
  logic push;
  logic pop;
  logic clear;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic [$clog2(DEPTH):0] count;
  modport owner (output push, output pop, output clear, output wdata,
    input rdata, input count);
  modport fifo (input push, input pop, input clear, input wdata,
    output rdata, output count);
endinterface : ftaa_fifo_if

// *** src/ftaa_lane_fifo.sv ***
// One small FIFO lane with registered read data and its own pointers.
// Assumes the owner never pops empty or pushes full; such requests are dropped.
module ftaa_lane_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  ftaa_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic [W-1:0] rd_q;
  wire do_push = f.push && (cnt_q != (AW+1)'(DEPTH));
  wire do_pop = f.pop && (cnt_q != '0);
  // Each lane keeps private pointers so lanes never disturb each other. [RL24]
  always_ff @(posedge clk_sys) begin
    if (rst || f.clear) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rd_q <= '0;
    end else begin
      if (do_push) begin
        mem_q[wp_q] <= f.wdata;
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= mem_q[rp_q];
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
  assign f.rdata = rd_q;
  assign f.count = cnt_q;
endmodule : ftaa_lane_fifo

// *** src/ftaa_pkg.sv ***
// Package for the FIFO test access and abort block.
// Assumes a 32-bit Avalon-MM register bus at 100 MHz; byte offsets are word aligned.
package ftaa_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_FIFO_TEST_CONTROL = 6'h00;
  localparam logic [5:0] OFF_TEST_PARITY_STAGE = 6'h04;
  localparam logic [5:0] OFF_DMA_FIFO_TEST_DATA = 6'h08;
  localparam logic [5:0] OFF_TEST_PARITY_STATUS = 6'h0C;
  localparam logic [5:0] OFF_SCSI_FIFO_READOUT = 6'h10;
  localparam logic [5:0] OFF_SCSI_OUTPUT_DATA_LATCH = 6'h14;
  localparam logic [5:0] OFF_SCSI_CONTROL_ZERO = 6'h18;
  localparam logic [5:0] OFF_SCSI_CONTROL_ONE = 6'h1C;
  localparam logic [5:0] OFF_SCSI_STATUS_ONE = 6'h20;
  localparam logic [5:0] OFF_SCSI_STATUS_TWO = 6'h24;
  localparam logic [5:0] OFF_DMA_FIFO_COUNT_CONTROL = 6'h28;
  localparam logic [5:0] OFF_BYTE_COUNTER = 6'h2C;
  localparam logic [5:0] OFF_DMA_STATUS = 6'h30;
  localparam logic [5:0] OFF_INTERRUPT_STATUS = 6'h34;
  localparam logic [5:0] OFF_SCRIPT_POINTER = 6'h38;
  localparam logic [5:0] OFF_SCSI_INPUT_DATA_LATCH = 6'h3C;
  localparam int unsigned BIT_LANE_ENABLE = 2;
  localparam int unsigned BIT_SCSI_FIFO_WE = 3;
  localparam int unsigned BIT_TEST_PARITY = 3;
  localparam int unsigned BIT_SCSI_PARITY = 4;
  localparam int unsigned BIT_PARITY_GEN = 2;
  localparam int unsigned BIT_EVEN_SCSI_PARITY = 2;
  localparam int unsigned BIT_CLEAR_FIFOS = 6;
  localparam int unsigned BIT_SOFT_ABORT = 7;
  localparam int unsigned BIT_ABORT_INT = 0;
  localparam int unsigned BIT_RUNNING = 1;
  localparam int unsigned BIT_INPUT_LATCH_FULL = 7;
  localparam int unsigned BIT_SYNC_OUT_FULL = 6;
  localparam int unsigned BIT_OUT_LATCH_FULL = 5;
  localparam int unsigned BIT_BURST_BUSY = 0;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
  localparam logic [5:0] COUNT_MASK = 6'h3F;
endpackage : ftaa_pkg

// *** src/ftaa_top.sv ***
// FIFO test access, abort control and residue status registers.
// Assumes an Avalon-MM master on clk_sys; pins arrive asynchronously.
// Notes on behaviour
// [RL1] DMA FIFO 36 bits, 8 entries, FIFO order
// [RL2] Four 9-bit lanes, each 8 deep
// [RL3] Three-bit lane select; top bit enables access
// [RL4] Test parity from staged bit 3
// [RL5] Data write pushes byte plus parity
// [RL6] Data read pops; parity in status bit 3
// [RL7] Host disables lane access before scripts
// [RL8] Write enable routes latch writes into FIFO
// [RL9] Readout pop captures parity in bit 4
// [RL10] Without generation, parity from lane pin
// [RL11] Generated parity odd or even by select
// [RL12] Abort halts scripts only
// [RL13] Hardware abort needs parity generation on
// [RL14] DMA status read clears abort interrupt
// [RL15] Interrupt status bit 7 requests abort
// [RL16] Finish burst, drain DMA FIFO, then interrupt
// [RL17] Counter decrements at memory; latch flagged
// [RL18] Status two bits 7-4 give count
// [RL19] Count register minus counter gives bytes
// [RL20] Latch full bit 5, output full 6
// [RL21] Bit 6 clears both FIFOs
// [RL22] Resume after clear and new pointer
// [RL23] Even parity select is control one bit 2
// [RL24] Lanes keep private pointers
module ftaa_top #(
  parameter int DEPTH = 8,
  parameter int SCSI_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] host_parity_pins,
  input wire logic parity3_abort_pin_n,
  input wire logic burst_active,
  input wire logic scsi_receive,
  input wire logic sync_mode,
  input wire logic byte_to_memory,
  input wire logic [7:0] input_latch_byte,
  input wire logic input_latch_load,
  input wire logic sync_out_load,
  input wire logic sync_out_sent,
  output logic script_run,
  output logic abort_irq
);
  if (DEPTH != 8 || SCSI_DEPTH > 15) begin : g_bad_depth
    $error("unsupported FIFO depth");
  end
  // The parity and abort pins pass two flip-flops before use; the other inputs are used directly.
  logic [3:0] dp_s1_q, dp_s2_q;
  logic ab_s1_q, ab_s2_q;
  always_ff @(posedge clk_sys) begin
    dp_s1_q <= host_parity_pins;
    dp_s2_q <= dp_s1_q;
    ab_s1_q <= parity3_abort_pin_n;
    ab_s2_q <= ab_s1_q;
  end

  // A read or write is answered in the cycle after it is seen, so waitrequest
  // is high for exactly the first cycle of each request.
  logic ack_q;
  wire req = (avs_read || avs_write) && !ack_q;
  always_ff @(posedge clk_sys) begin
    if (rst) ack_q <= 1'b0;
    else ack_q <= req;
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  wire wr = avs_write && ack_q;
  wire rd = avs_read && ack_q;
  wire [7:0] wb = avs_writedata[7:0];
  wire hit_ctl = avs_address == ftaa_pkg::OFF_FIFO_TEST_CONTROL;
  wire hit_stage = avs_address == ftaa_pkg::OFF_TEST_PARITY_STAGE;
  wire hit_data = avs_address == ftaa_pkg::OFF_DMA_FIFO_TEST_DATA;
  wire hit_pstat = avs_address == ftaa_pkg::OFF_TEST_PARITY_STATUS;
  wire hit_rdout = avs_address == ftaa_pkg::OFF_SCSI_FIFO_READOUT;
  wire hit_odl = avs_address == ftaa_pkg::OFF_SCSI_OUTPUT_DATA_LATCH;
  wire hit_c0 = avs_address == ftaa_pkg::OFF_SCSI_CONTROL_ZERO;
  wire hit_c1 = avs_address == ftaa_pkg::OFF_SCSI_CONTROL_ONE;
  wire hit_s1 = avs_address == ftaa_pkg::OFF_SCSI_STATUS_ONE;
  wire hit_s2 = avs_address == ftaa_pkg::OFF_SCSI_STATUS_TWO;
  wire hit_dfc = avs_address == ftaa_pkg::OFF_DMA_FIFO_COUNT_CONTROL;
  wire hit_bc = avs_address == ftaa_pkg::OFF_BYTE_COUNTER;
  wire hit_dst = avs_address == ftaa_pkg::OFF_DMA_STATUS;
  wire hit_ist = avs_address == ftaa_pkg::OFF_INTERRUPT_STATUS;
  wire hit_sp = avs_address == ftaa_pkg::OFF_SCRIPT_POINTER;
  wire hit_idl = avs_address == ftaa_pkg::OFF_SCSI_INPUT_DATA_LATCH;

  // Control registers.
  logic [7:0] fifo_test_control_q, test_parity_stage_q;
  logic [7:0] scsi_control_zero_q, scsi_control_one_q;
  logic [31:0] script_pointer_q, byte_counter_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fifo_test_control_q <= 8'h00;
      test_parity_stage_q <= 8'h00;
      scsi_control_zero_q <= 8'h00;
      scsi_control_one_q <= 8'h00;
      script_pointer_q <= 32'h0000_0000;
    end else begin
      if (wr && hit_ctl) fifo_test_control_q <= wb;
      if (wr && hit_stage) test_parity_stage_q <= wb;
      if (wr && hit_c0) scsi_control_zero_q <= wb;
      if (wr && hit_c1) scsi_control_one_q <= wb;
      if (wr && hit_sp) script_pointer_q <= avs_writedata;
    end
  end
  wire [2:0] lane_sel = fifo_test_control_q[2:0];
  wire lane_access_enable = lane_sel[ftaa_pkg::BIT_LANE_ENABLE]; // [RL3] [RL7]
  wire [1:0] lane_index = lane_sel[1:0]; // [RL3]
  wire scsi_fifo_we = fifo_test_control_q[ftaa_pkg::BIT_SCSI_FIFO_WE];
  wire parity_generation_enable = scsi_control_zero_q[ftaa_pkg::BIT_PARITY_GEN];
  wire even_scsi_parity_select = scsi_control_one_q[ftaa_pkg::BIT_EVEN_SCSI_PARITY]; // [RL23]
  wire clear_fifos = wr && hit_dfc && wb[ftaa_pkg::BIT_CLEAR_FIFOS]; // [RL21]

  // DMA FIFO: four 9-bit lanes of 8 entries, 36 bits across. [RL1] [RL2]
  logic [3:0] lane_push, lane_pop;
  logic [8:0] lane_rd [4];
  logic [3:0] lane_cnt [4];
  logic any_empty;
  logic drain_busy;
  wire test_push = wr && hit_data && lane_access_enable; // [RL5]
  wire test_pop = rd && hit_data && lane_access_enable; // [RL6]
  wire drain_pop = drain_busy;
  wire [8:0] test_word = {test_parity_stage_q[ftaa_pkg::BIT_TEST_PARITY], wb}; // [RL4]
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gl
      ftaa_fifo_if #(.W(9), .DEPTH(DEPTH)) lf ();
      assign lane_push[g] = test_push && (lane_index == 2'(g));
      assign lane_pop[g] = (test_pop && (lane_index == 2'(g))) || drain_pop;
      assign lf.push = lane_push[g];
      assign lf.pop = lane_pop[g];
      assign lf.clear = clear_fifos;
      assign lf.wdata = test_word;
      assign lane_rd[g] = lf.rdata;
      assign lane_cnt[g] = lf.count;
      ftaa_lane_fifo #(.W(9), .DEPTH(DEPTH)) u_lane (
        .clk_sys(clk_sys),
        .rst(rst),
        .f(lf)
      );
    end
  endgenerate
  assign any_empty = (lane_cnt[0] == 4'd0) && (lane_cnt[1] == 4'd0)
    && (lane_cnt[2] == 4'd0) && (lane_cnt[3] == 4'd0);
  // The pop takes one cycle to land in the lane's output register, so the
  // byte is shown from a read that follows the popping read.
  wire [8:0] sel_lane_word = lane_rd[lane_index];

  // SCSI synchronous FIFO.
  ftaa_fifo_if #(.W(9), .DEPTH(SCSI_DEPTH)) sf ();
  logic [1:0] wr_lane;
  always_comb begin
    wr_lane = 2'd0;
    if (avs_writedata[31:24] != 8'h00) wr_lane = 2'd3;
    else if (avs_writedata[23:16] != 8'h00) wr_lane = 2'd2;
    else if (avs_writedata[15:8] != 8'h00) wr_lane = 2'd1;
  end
  wire [7:0] odl_byte = avs_writedata[8*wr_lane +: 8];
  // Generated parity is odd unless even is selected. [RL11]
  wire gen_par = ~(^odl_byte) ^ even_scsi_parity_select;
  wire pin_par = dp_s2_q[wr_lane]; // [RL10]
  wire scsi_par = parity_generation_enable ? gen_par : pin_par;
  wire odl_write = wr && hit_odl;
  assign sf.push = odl_write && scsi_fifo_we; // [RL8]
  assign sf.pop = rd && hit_rdout; // [RL9]
  assign sf.clear = clear_fifos; // [RL21]
  assign sf.wdata = {scsi_par, odl_byte};
  ftaa_lane_fifo #(.W(9), .DEPTH(SCSI_DEPTH)) u_scsi (
    .clk_sys(clk_sys),
    .rst(rst),
    .f(sf)
  );

  // Parity status captured on each host read pop (not on drain pops), and latch status.
  logic dma_par_q, scsi_par_q, pop_dma_q, pop_scsi_q;
  logic out_latch_full_q, sync_out_full_q, in_latch_full_q;
  logic [7:0] in_latch_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pop_dma_q <= 1'b0;
      pop_scsi_q <= 1'b0;
      dma_par_q <= 1'b0;
      scsi_par_q <= 1'b0;
      out_latch_full_q <= 1'b0;
      sync_out_full_q <= 1'b0;
      in_latch_full_q <= 1'b0;
      in_latch_q <= 8'h00;
    end else begin
      pop_dma_q <= test_pop;
      pop_scsi_q <= sf.pop;
      if (pop_dma_q) dma_par_q <= sel_lane_word[8]; // [RL6]
      if (pop_scsi_q) scsi_par_q <= sf.rdata[8]; // [RL9]
      // Set wins over clear for the latch flags. [RL20]
      if (odl_write && !scsi_fifo_we) out_latch_full_q <= 1'b1;
      else if (clear_fifos) out_latch_full_q <= 1'b0;
      if (sync_out_load) sync_out_full_q <= 1'b1;
      else if (sync_out_sent || clear_fifos) sync_out_full_q <= 1'b0;
      // The latch byte stays until read, as it was never counted. [RL17]
      if (input_latch_load) begin
        in_latch_full_q <= 1'b1;
        in_latch_q <= input_latch_byte;
      end else if (rd && hit_idl) in_latch_full_q <= 1'b0;
    end
  end

  // Byte counter moves only when a byte reaches memory. [RL17]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      byte_counter_q <= 32'h0000_0000;
    end else begin
      if (wr && hit_bc) byte_counter_q <= avs_writedata;
      else if (byte_to_memory) byte_counter_q <= byte_counter_q - 32'h0000_0001;
    end
  end
  // Count register minus counter, masked, gives bytes held. [RL19]
  // Each lane count is widened first so the carry of the sum is kept.
  wire [5:0] held = 6'(lane_cnt[0]) + 6'(lane_cnt[1]) + 6'(lane_cnt[2]) + 6'(lane_cnt[3]);
  wire [5:0] dma_count_value = (byte_counter_q[5:0] + held) & ftaa_pkg::COUNT_MASK;

  // Abort and script control.
  typedef enum logic [1:0] {RUN, FINISH, DRAIN, HALTED} ftaa_abort_type;
  ftaa_abort_type st_q, st_d;
  logic abort_int_q, soft_abort_q;
  wire soft_wr = wr && hit_ist;
  wire hw_abort = !ab_s2_q && parity_generation_enable; // [RL13]
  wire abort_req = hw_abort || soft_abort_q; // [RL15]
  wire raise_int = (st_q == DRAIN) && (any_empty || !scsi_receive);
  assign drain_busy = (st_q == DRAIN) && scsi_receive && !any_empty;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      RUN: if (abort_req) st_d = FINISH;
      FINISH: if (!burst_active) st_d = DRAIN; // [RL16]
      DRAIN: if (raise_int) st_d = HALTED; // [RL16]
      HALTED: if (!abort_int_q && wr && hit_sp) st_d = RUN; // [RL22]
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= RUN;
      soft_abort_q <= 1'b0;
      abort_int_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (soft_wr) soft_abort_q <= avs_writedata[ftaa_pkg::BIT_SOFT_ABORT]; // [RL15]
      // Set wins over the clearing read; a held soft abort keeps raising it. [RL14] [RL15]
      if (raise_int || (st_q == HALTED && soft_abort_q))
        abort_int_q <= 1'b1;
      else if (rd && hit_dst) abort_int_q <= 1'b0;
    end
  end
  // Only script execution stops; no other state is reset by an abort. [RL12]
  assign script_run = (st_q == RUN) || (st_q == FINISH);
  assign abort_irq = abort_int_q;

  // Read mux.
  wire [7:0] s1 = {in_latch_full_q, sync_out_full_q, out_latch_full_q, 5'b0_0000}; // [RL20]
  wire [7:0] s2 = {sync_mode ? 4'(sf.count) : 4'h0, 4'h0}; // [RL18]
  wire [7:0] pstat = {3'b000, scsi_par_q, dma_par_q, 3'b000};
  wire [7:0] dst = {6'h00, burst_active, abort_int_q};
  wire [7:0] ist = {soft_abort_q, 4'h0, st_q == HALTED, script_run, abort_int_q};
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = ftaa_pkg::READ_UNMAPPED;
    if (hit_ctl) rdata_d = {24'h00_0000, fifo_test_control_q};
    if (hit_stage) rdata_d = {24'h00_0000, test_parity_stage_q};
    if (hit_data) rdata_d = {24'h00_0000, sel_lane_word[7:0]};
    if (hit_pstat) rdata_d = {24'h00_0000, pstat};
    if (hit_rdout) rdata_d = {24'h00_0000, sf.rdata[7:0]};
    if (hit_c0) rdata_d = {24'h00_0000, scsi_control_zero_q};
    if (hit_c1) rdata_d = {24'h00_0000, scsi_control_one_q};
    if (hit_s1) rdata_d = {24'h00_0000, s1};
    if (hit_s2) rdata_d = {24'h00_0000, s2};
    if (hit_dfc) rdata_d = {26'h000_0000, dma_count_value};
    if (hit_bc) rdata_d = byte_counter_q;
    if (hit_dst) rdata_d = {24'h00_0000, dst};
    if (hit_ist) rdata_d = {24'h00_0000, ist};
    if (hit_sp) rdata_d = script_pointer_q;
    if (hit_idl) rdata_d = {24'h00_0000, in_latch_q};
  end
  always_ff @(posedge clk_sys) begin
    if (rst) avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack_q) avs_readdata <= rdata_d;
  end
endmodule : ftaa_top

// *** tb/ftaa_host_model.sv ***
// Host processor model issuing Avalon-MM register reads and writes.
// Assumes the bench top owns the failure counter and the closing report.
module ftaa_host_model (
  input wire logic clk_sys,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 6'h00;
    {avs_read, avs_write} = 2'h0;
    avs_writedata = 32'h0000_0000;
  end
  // An idle edge before each request keeps a release and the next raise apart.
  task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // Waitrequest and read data are taken as they stand at the rising edge.
    repeat (40) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) begin
        q = avs_readdata;
        {avs_read, avs_write} <= 2'h0;
        avs_writedata <= ~d;
        return;
      end
    end
    testbench.failures++;
    testbench.tally_and_finish();
  endtask : access
endmodule : ftaa_host_model

// *** tb/ftaa_top_asserts.sv ***
// Checker for the abort sequencing and bus wait state of ftaa_top.
// Assumes it is bound into ftaa_top and sees nothing but that module's ports.
module ftaa_top_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic parity3_abort_pin_n,
  input wire logic burst_active,
  input wire logic script_run,
  input wire logic abort_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pgen_q;
  logic soft_q;
  wire take_w = avs_write && !avs_waitrequest;
  wire take_r = avs_read && !avs_waitrequest;
  wire wr_ctl0 = take_w && avs_address == ftaa_pkg::OFF_SCSI_CONTROL_ZERO;
  wire wr_isr = take_w && avs_address == ftaa_pkg::OFF_INTERRUPT_STATUS;
  // Shadows of the two abort enables, so gating can be judged from the bus alone.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pgen_q <= 1'b0;
      soft_q <= 1'b0;
    end else begin
      if (wr_ctl0) pgen_q <= avs_writedata[ftaa_pkg::BIT_PARITY_GEN];
      if (wr_isr) soft_q <= avs_writedata[ftaa_pkg::BIT_SOFT_ABORT];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_halted;
    abort_irq && !script_run;
  endsequence
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state too long");
  property p_soft;
    wr_isr && avs_writedata[ftaa_pkg::BIT_SOFT_ABORT] && script_run && !burst_active
      |-> ##[1:16] s_halted;
  endproperty
  a_soft: assert property (p_soft) else $error("soft abort not honoured");
  property p_hw_on;
    pgen_q && !parity3_abort_pin_n && script_run && !abort_irq && !burst_active
      |-> ##[1:16] s_halted;
  endproperty
  a_hw_on: assert property (p_hw_on) else $error("pin abort not honoured");
  property p_hw_gate;
    script_run && !pgen_q && !soft_q |=> script_run;
  endproperty
  a_hw_gate: assert property (p_hw_gate) else $error("halt without enabled abort");
  property p_burst;
    $rose(abort_irq) |-> !$past(burst_active);
  endproperty
  a_burst: assert property (p_burst) else $error("interrupt during burst");
  property p_clear;
    take_r && avs_address == ftaa_pkg::OFF_DMA_STATUS && abort_irq && !soft_q |=> !abort_irq;
  endproperty
  a_clear: assert property (p_clear) else $error("status read left interrupt");
  property p_halt;
    $rose(abort_irq) |-> !script_run;
  endproperty
  a_halt: assert property (p_halt) else $error("interrupt while running");
  property p_resume;
    take_w && avs_address == ftaa_pkg::OFF_SCRIPT_POINTER && !script_run && !abort_irq
      && !soft_q |-> ##[1:2] script_run;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after pointer");
endmodule : ftaa_top_asserts

bind ftaa_top ftaa_top_asserts chk_u (.clk_sys(clk_sys), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .parity3_abort_pin_n(parity3_abort_pin_n), .burst_active(burst_active),
  .script_run(script_run), .abort_irq(abort_irq));

// *** tb/testbench.sv ***
// Bench for ftaa_top: lane and SCSI FIFO tests, residue status, aborts.
// Assumes the host model makes every register access; pins are driven here.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  int failures = 0;
  int checks = 0;
  logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, parity3_abort_pin_n;
  logic burst_active, scsi_receive, sync_mode, byte_to_memory, input_latch_load;
  logic sync_out_load, sync_out_sent, script_run, abort_irq;
  logic [3:0] host_parity_pins;
  logic [3:0] pins [4] = '{4'hB, 4'hB, 4'h4, 4'hB};
  logic [5:0] avs_address;
  logic [7:0] input_latch_byte;
  logic [7:0] sd [4] = '{8'h07, 8'h07, 8'h1F, 8'h0F};
  logic [31:0] avs_writedata, avs_readdata, rv, bv, cv;
  ftaa_top dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .host_parity_pins(host_parity_pins), .parity3_abort_pin_n(parity3_abort_pin_n),
    .burst_active(burst_active), .scsi_receive(scsi_receive), .sync_mode(sync_mode),
    .byte_to_memory(byte_to_memory), .input_latch_byte(input_latch_byte),
    .input_latch_load(input_latch_load), .sync_out_load(sync_out_load),
    .sync_out_sent(sync_out_sent), .script_run(script_run), .abort_irq(abort_irq));
  ftaa_host_model host_u (.clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    host_u.access(1'b1, a, d, bv);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    host_u.access(1'b0, a, 32'h0000_0000, rv);
  endtask : rd
  task automatic rc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk_reg(rv & m, e);
  endtask : rc
  task automatic wait_irq();
    for (int n = 0; n < 80; n++) begin
      @(posedge clk_sys);
      if (abort_irq === 1'b1) return;
    end
    failures++;
    tally_and_finish();
  endtask : wait_irq
  // Generated parity is odd, then even; the last two entries take lane two's pin.
  function automatic logic sp(input int k);
    return (k == 0) ? ~^sd[k] : (k == 1) ? ^sd[k] : pins[k][2];
  endfunction : sp
  initial begin
    rst = 1'b1;
    host_parity_pins = 4'h0;
    parity3_abort_pin_n = 1'b1;
    {burst_active, scsi_receive, sync_mode, byte_to_memory} = 4'h0;
    {input_latch_load, sync_out_load, sync_out_sent} = 3'h0;
    input_latch_byte = 8'h00;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    wr(6'h00, 8'h03);
    wr(6'h08, 8'h55);
    // The ninth push per lane meets a full lane and must vanish.
    for (int l = 0; l < 4; l++) begin
      wr(6'h00, 8'h04 | l);
      for (int i = 0; i < 9; i++) begin
        wr(6'h04, ((i ^ l) & 1) << 3);
        wr(6'h08, (i == 8) ? 8'hEE : 16 * l + i);
      end
    end
    for (int l = 0; l < 4; l++) begin
      wr(6'h00, 8'h04 | l);
      for (int i = 0; i < 9; i++) begin
        rd(6'h08);
        if (i > 0) chk_reg(rv & 8'hFF, 16 * l + i - 1);
        if (i < 8) rc(6'h0C, 8'h08, ((i ^ l) & 1) << 3);
      end
    end
    sync_mode <= 1'b1;
    wr(6'h00, 8'h08);
    for (int k = 0; k < 4; k++) begin
      host_parity_pins <= pins[k];
      wr(6'h18, (k < 2) ? 8'h04 : 8'h00);
      wr(6'h1C, (k == 1) ? 8'h04 : 8'h00);
      wr(6'h14, {sd[k], 16'h0000});
    end
    rc(6'h24, 8'hF0, 8'h40);
    for (int k = 0; k < 5; k++) begin
      rd(6'h10);
      if (k > 0) chk_reg(rv & 8'hFF, sd[k - 1]);
      if (k < 4) rc(6'h0C, 8'h10, {sp(k), 4'h0});
    end
    rc(6'h24, 8'hF0, 8'h00);
    wr(6'h2C, 32'h0000_0105);
    wr(6'h00, 8'h04);
    repeat (3) wr(6'h08, 8'h11);
    wr(6'h00, 8'h00);
    rd(6'h28);
    cv = rv;
    rd(6'h2C);
    chk_reg((cv - rv) & ftaa_pkg::COUNT_MASK, 8'h03);
    wr(6'h14, 8'h5A);
    input_latch_byte <= 8'hA5;
    {input_latch_load, sync_out_load, byte_to_memory} <= 3'h7;
    @(posedge clk_sys);
    {input_latch_load, sync_out_load, byte_to_memory} <= 3'h0;
    rc(6'h20, 8'hE0, 8'hE0);
    rc(6'h3C, 8'hFF, 8'hA5);
    rc(6'h2C, 32'hFFFF_FFFF, 32'h0000_0104);
    sync_out_sent <= 1'b1;
    @(posedge clk_sys);
    sync_out_sent <= 1'b0;
    wr(6'h28, 8'h40);
    rc(6'h20, 8'h60, 8'h00);
    parity3_abort_pin_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk_pin(script_run, 1'b1);
    wr(6'h00, 8'h05);
    repeat (2) wr(6'h08, 8'h22);
    wr(6'h00, 8'h00);
    {burst_active, scsi_receive} <= 2'h3;
    wr(6'h18, 8'h04);
    repeat (10) @(posedge clk_sys);
    chk_pin(abort_irq, 1'b0);
    burst_active <= 1'b0;
    wait_irq();
    chk_pin(script_run, 1'b0);
    {parity3_abort_pin_n, scsi_receive} <= 2'h2;
    rc(6'h2C, 32'hFFFF_FFFF, 32'h0000_0104);
    rc(6'h30, 8'h01, 8'h01);
    @(negedge clk_sys);
    chk_pin(abort_irq, 1'b0);
    wr(6'h38, 32'h0000_0200);
    repeat (2) @(negedge clk_sys);
    chk_pin(script_run, 1'b1);
    wr(6'h18, 8'h00);
    wr(6'h34, 8'h80);
    wait_irq();
    rc(6'h30, 8'h01, 8'h01);
    wait_irq();
    wr(6'h34, 8'h00);
    rc(6'h30, 8'h01, 8'h01);
    @(negedge clk_sys);
    chk_pin(abort_irq, 1'b0);
    wr(6'h38, 32'h0000_0300);
    repeat (2) @(negedge clk_sys);
    chk_pin(script_run, 1'b1);
    tally_and_finish();
  end
endmodule : testbench
